// File: logic/trim_link_pkg.sv
/*
 * Shared constants and types for the two-wire trim link master.
 * Assumes a 10 MHz system clock and an open-drain bus with pull-ups
 * on both lines, resolved outside this logic.
 */
// Overview of operation
// - Keep data steady while clock high
// - Data falling, clock high opens session
// - Data rising, clock high closes session
// - Master alone opens/closes; busy until close
// - Bytes are eight bits, MSB first
// - Sender releases data at ninth pulse
// - Master clocks every acknowledge pulse
// - First byte: seven-bit address plus direction
// - Second write byte selects register index
// - Third write byte is register value
// - Read preceded by write setting index
package trim_link_pkg;

	// ----------------------------------------------------------------
	// Bus addressing and register indices
	// ----------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h28;
	localparam logic DIR_WRITE = 1'h0;
	localparam logic DIR_READ = 1'h1;
	localparam logic [7:0] REG_SWITCH_TRIM = 8'h01;
	localparam logic [7:0] REG_LINEAR_TRIM = 8'h02;
	localparam logic [7:0] REG_OTP_CTRL = 8'hFF;
	localparam logic [7:0] SWITCH_TRIM_DEFAULT = 8'h1F;
	localparam logic [7:0] LINEAR_TRIM_DEFAULT = 8'h07;

	// ----------------------------------------------------------------
	// Timing: one quarter of a bus clock period
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 10;
	localparam int T_QUARTER_NS = 700;
	localparam int QUARTER_CYC = (T_QUARTER_NS * CLK_MHZ + 999) / 1000;
	localparam int DIV_W = 8;

	// ----------------------------------------------------------------
	// Byte sequence positions and bit counts
	// ----------------------------------------------------------------
	localparam logic [1:0] BYTE_ADDR = 2'h0;
	localparam logic [1:0] BYTE_INDEX = 2'h1;
	localparam logic [1:0] BYTE_DATA = 2'h2;
	localparam logic [1:0] BYTE_RDATA = 2'h3;
	localparam logic [3:0] ACK_BIT = 4'h8;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_BIT = 2'b10,
		ST_STOP = 2'b11
	} link_state_t;

	// Request from the user side
	typedef struct packed {
		logic rd;
		logic [7:0] index;
		logic [7:0] wdata;
	} trim_cmd_t;

	// Whole state of the master
	typedef struct packed {
		link_state_t st;
		logic [1:0] q;
		logic [DIV_W-1:0] div;
		logic [3:0] bit_cnt;
		logic [1:0] byte_idx;
		logic [7:0] shift;
		trim_cmd_t cmd;
		logic [2:0] sda_s;
		logic sda_lvl;
		logic scl_oe;
		logic sda_oe;
		logic busy;
		logic done;
		logic nack;
		logic [7:0] rdata;
	} link_regs_t;

	localparam link_regs_t LINK_RESET = '{
		st: ST_IDLE, q: 2'h0, div: '0, bit_cnt: 4'h0, byte_idx: 2'h0,
		shift: 8'h00, cmd: '0, sda_s: 3'h7, sda_lvl: 1'h1,
		scl_oe: 1'h0, sda_oe: 1'h0, busy: 1'h0, done: 1'h0,
		nack: 1'h0, rdata: 8'h00};

endpackage : trim_link_pkg

// File: logic/trim_link_master.sv
/*
 * Two-wire bus master that writes and reads the trim registers of an
 * LED driver slave. A write sends address, index and value; a read
 * sends address and index, a repeated opening, address with the read
 * direction, and takes one byte which it does not acknowledge.
 * Assumes open-drain pins: an enable high pulls the line low, and the
 * bench resolves the wire with pull-ups. No clock stretching.
 */
module trim_link_master
#(
	parameter int QUARTER = trim_link_pkg::QUARTER_CYC
)
(
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire trim_link_pkg::trim_cmd_t cmd_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic scl_o,
	output logic scl_oe_o,
	output logic busy_o,
	output logic done_o,
	output logic nack_o,
	output logic [7:0] rdata_o
);
	import trim_link_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	generate
		if (QUARTER < 4 || QUARTER >= (1 << DIV_W))
		begin : g_bad_quarter
			$error("QUARTER must lie between 4 and 255");
		end
	endgenerate

	localparam logic [DIV_W-1:0] QRELOAD = DIV_W'(QUARTER - 1);

	link_regs_t s;
	link_regs_t next_s;
	logic tick;
	logic tx_byte;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte sent at a given position of the sequence
	function automatic logic [7:0] load_byte(input logic [1:0] idx,
		input trim_cmd_t c);
		logic [7:0] b;
		b = 8'h00;
		unique case (idx)
			BYTE_ADDR: b = {DEV_ADDR, DIR_WRITE};
			BYTE_INDEX: b = c.index;
			BYTE_DATA: b = c.rd ? {DEV_ADDR, DIR_READ} : c.wdata;
			BYTE_RDATA: b = 8'h00;
		endcase
		return b;
	endfunction : load_byte

	assign tick = (s.div == '0);
	assign tx_byte = !(s.cmd.rd && s.byte_idx == BYTE_RDATA);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		next_s.done = 1'h0;
		// Three-stage synchroniser; accept a level once the last two stages agree
		next_s.sda_s = {s.sda_s[1:0], sda_i};
		if (s.sda_s[1] == s.sda_s[2])
		begin
			next_s.sda_lvl = s.sda_s[2];
		end
		if (s.st != ST_IDLE)
		begin
			next_s.div = tick ? QRELOAD : s.div - 1'b1;
		end
		if (s.st != ST_IDLE && tick)
		begin
			next_s.q = s.q + 1'b1;
		end
		unique case (s.st)
			ST_IDLE:
			begin
				if (go_i)
				begin
					next_s.cmd = cmd_i;
					next_s.st = ST_START;
					next_s.byte_idx = BYTE_ADDR;
					next_s.nack = 1'h0;
					next_s.busy = 1'h1;
					next_s.q = 2'h0;
					next_s.div = QRELOAD;
				end
			end
			ST_START:
			begin
				if (tick)
				begin
					unique case (s.q)
						2'h0:
						begin
							// Repeated opening pulls clock low first
							next_s.scl_oe = (s.byte_idx != BYTE_ADDR);
							next_s.sda_oe = 1'h0;
						end
						2'h1: next_s.scl_oe = 1'h0;
						2'h2: next_s.sda_oe = 1'h1;
						2'h3:
						begin
							next_s.st = ST_BIT;
							next_s.bit_cnt = 4'h0;
							next_s.shift = load_byte(s.byte_idx, s.cmd);
						end
					endcase
				end
			end
			ST_BIT:
			begin
				if (tick)
				begin
					unique case (s.q)
						2'h0:
						begin
							// Clock falls first; data waits a quarter
							next_s.scl_oe = 1'h1;
						end
						2'h1:
						begin
							// Data changes only while clock is low
							next_s.sda_oe = (s.bit_cnt != ACK_BIT) && tx_byte
								&& !s.shift[7];
						end
						2'h2: next_s.scl_oe = 1'h0;
						2'h3:
						begin
							next_s.bit_cnt = s.bit_cnt + 1'b1;
							if (s.bit_cnt != ACK_BIT)
							begin
								next_s.shift = {s.shift[6:0], s.sda_lvl};
							end
							else if (tx_byte && s.sda_lvl)
							begin
								next_s.nack = 1'h1;
								next_s.st = ST_STOP;
							end
							else if (!tx_byte)
							begin
								next_s.rdata = s.shift;
								next_s.st = ST_STOP;
							end
							else if (!s.cmd.rd && s.byte_idx == BYTE_DATA)
							begin
								next_s.st = ST_STOP;
							end
							else if (s.cmd.rd && s.byte_idx == BYTE_INDEX)
							begin
								// Index set, now reopen for the read
								next_s.st = ST_START;
								next_s.byte_idx = BYTE_DATA;
							end
							else
							begin
								next_s.byte_idx = s.byte_idx + 1'b1;
								next_s.bit_cnt = 4'h0;
								next_s.shift = load_byte(s.byte_idx + 1'b1,
									s.cmd);
							end
						end
					endcase
				end
			end
			ST_STOP:
			begin
				if (tick)
				begin
					unique case (s.q)
						2'h0: next_s.scl_oe = 1'h1;
						2'h1: next_s.sda_oe = 1'h1;
						2'h2: next_s.scl_oe = 1'h0;
						2'h3:
						begin
							next_s.sda_oe = 1'h0;
							next_s.st = ST_IDLE;
							next_s.busy = 1'h0;
							next_s.done = 1'h1;
						end
					endcase
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			s <= LINK_RESET;
		end
		else
		begin
			s <= next_s;
		end
	end

	// Enables and status straight from the state register; pin levels tied low
	assign sda_o = 1'h0;
	assign scl_o = 1'h0;
	assign sda_oe_o = s.sda_oe;
	assign scl_oe_o = s.scl_oe;
	assign busy_o = s.busy;
	assign done_o = s.done;
	assign nack_o = s.nack;
	assign rdata_o = s.rdata;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	data_stable_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(s.st == ST_BIT && $changed(s.sda_oe))
		|-> (s.scl_oe && $past(s.scl_oe)))
		else $error("data moved while clock high");

	open_edge_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(s.st == ST_START && s.q == 2'h2 && tick)
		##1 1 |-> (s.sda_oe && !s.scl_oe && !$past(s.sda_oe)))
		else $error("opening not data fall with clock high");

	close_edge_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(s.st == ST_STOP && s.q == 2'h3 && tick)
		|=> (!s.sda_oe && !s.scl_oe && done_o && !busy_o))
		else $error("closing not data rise with clock high");

	busy_span_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(go_i && !busy_o) |=> busy_o ##1 (busy_o && !done_o))
		else $error("busy not raised on request");

	ack_release_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(s.st == ST_BIT && s.bit_cnt == ACK_BIT
		&& (s.q == 2'h2 || s.q == 2'h3))
		|-> !s.sda_oe)
		else $error("master drives data in acknowledge slot");

	ack_clock_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(s.st == ST_BIT && s.bit_cnt == ACK_BIT && s.q == 2'h2 && tick)
		|=> !scl_oe_o [*4])
		else $error("no clock pulse for acknowledge");

	addr_msb_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(s.st == ST_BIT && s.byte_idx == BYTE_ADDR && s.bit_cnt == 4'h0
		&& s.q == 2'h2) |-> (s.sda_oe == !DEV_ADDR[6]))
		else $error("address not sent first, MSB first");

	index_msb_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(s.st == ST_BIT && s.byte_idx == BYTE_INDEX && s.bit_cnt == 4'h0
		&& s.q == 2'h2) |-> (s.sda_oe == !s.cmd.index[7]))
		else $error("index byte not sent MSB first");

	read_reopen_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(s.st == ST_START && s.byte_idx == BYTE_DATA) |-> s.cmd.rd)
		else $error("reopening outside a read");

	busy_state_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		busy_o == (s.st != ST_IDLE))
		else $error("busy does not match bus ownership");

	bit_range_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(s.st == ST_BIT) |-> (s.bit_cnt <= ACK_BIT))
		else $error("more than nine pulses in a byte");

	dir_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(s.st == ST_BIT && s.byte_idx == BYTE_ADDR && s.bit_cnt == 4'h7
		&& s.q == 2'h2) |-> s.sda_oe)
		else $error("first address byte not a write");

	dir_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(s.st == ST_BIT && s.byte_idx == BYTE_DATA && s.cmd.rd
		&& s.bit_cnt == 4'h7 && s.q == 2'h2) |-> !s.sda_oe)
		else $error("reopened address not a read");

	read_release_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(s.st == ST_BIT && !tx_byte) |-> !s.sda_oe)
		else $error("master drives data during read byte");

	stop_prep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(s.st == ST_STOP && s.q == 2'h1 && tick) |-> s.scl_oe)
		else $error("data pulled low for closing with clock high");

	stop_setup_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		(s.st == ST_STOP && s.q == 2'h3 && tick) |-> (s.sda_oe && !s.scl_oe))
		else $error("closing not from data low with clock high");

endmodule : trim_link_master

// File: dv/trim_slave_model.sv
/*
 * Behavioural trim slave on the two-wire link.
 * Assumes the bench resolves both wires with pull-ups.
 */
module trim_slave_model
	import trim_link_pkg::*;
(
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic [6:0] own_addr_i,
	output logic sda_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sh, tx, idx, pend, otp;
	logic [5:0] sw_trim;
	logic [3:0] ln_trim;
	logic act, sel, rd, burnt;
	int bitc, byten;

	// Power-up load of both trims
	initial
	begin
		sw_trim = 6'h1F;
		ln_trim = 4'h7;
		otp = 8'h08;
		burnt = 1'b0;
		act = 1'b0;
		sda_oe_o = 1'b0;
	end

	// Register read view
	function automatic logic [7:0] rd_reg(input logic [7:0] i);
		case (i)
			8'h01: return {2'h0, sw_trim};
			8'h02: return {4'h0, ln_trim};
			8'hFF: return otp;
			default: return 8'h00;
		endcase
	endfunction : rd_reg

	// Opening, also mid-session, restarts address reception
	always @(negedge sda_i)
		if (scl_i)
		begin
			act = 1'b1;
			sel = 1'b1;
			rd = 1'b0;
			bitc = 0;
			byten = 0;
		end

	// Closing, or any rise with clock high mid-transfer, abandons the session
	always @(posedge sda_i)
		if (scl_i)
		begin
			act = 1'b0;
			sda_oe_o = 1'b0;
		end

	// Sample on rising clock; apply write at the final acknowledge
	always @(posedge scl_i)
		if (act)
		begin
			if (bitc < 8)
				sh = {sh[6:0], sda_i};
			else if (rd)
				sel = sel && !sda_i;
			else if (sel && byten == 3)
			begin
				case (idx)
					8'h01: sw_trim = pend[5:0];
					8'h02: ln_trim = pend[3:0];
					8'hFF: burnt = burnt | pend[2];
					default: ;
				endcase
				if (idx == 8'hFF && pend[0])
					otp[4] = burnt;
			end
			bitc = bitc + 1;
		end

	// Drive data and acknowledges while the clock is low
	always @(negedge scl_i)
		if (act)
		begin
			sda_oe_o = 1'b0;
			if (bitc == 8 && !rd)
			begin
				if (byten == 0)
				begin
					sel = sel && sh[7:1] == own_addr_i;
					rd = sh[0];
					tx = rd_reg(idx);
				end
				if (byten == 1)
					idx = sh;
				if (byten == 2)
					pend = sh;
				byten = byten + 1;
				sda_oe_o = sel;
			end
			else if (bitc == 9)
				bitc = 0;
			if (bitc < 8 && rd && sel)
				sda_oe_o = !tx[7 - bitc];
		end
endmodule : trim_slave_model

// File: dv/trim_link_master_tb_top.sv
/*
 * Self-checking bench for the trim link master and slave model.
 * Assumes pulled-up wires; QUARTER shortened to 4 cycles.
 */
module trim_link_master_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import trim_link_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, go = 1'b0;
	trim_cmd_t cmd = '0;
	logic [6:0] own_addr = 7'h28;
	logic m_oe, scl_oe, s_oe, busy, done, nack;
	logic [7:0] rdata;
	wire scl = scl_oe ? 1'b0 : 1'b1;
	wire sda = (m_oe | s_oe) ? 1'b0 : 1'b1;
	int err_count = 0, checks = 0, cyc = 0, starts, stops;

	always #50 mclk = ~mclk;

	trim_link_master #(.QUARTER(4)) dut (.mclk_i(mclk), .rst_i(rst),
		.go_i(go), .cmd_i(cmd), .sda_i(sda), .sda_o(), .sda_oe_o(m_oe),
		.scl_o(), .scl_oe_o(scl_oe), .busy_o(busy), .done_o(done),
		.nack_o(nack), .rdata_o(rdata));
	trim_slave_model peer (.scl_i(scl), .sda_i(sda),
		.own_addr_i(own_addr), .sda_oe_o(s_oe));

	// Bus condition counters
	always @(negedge sda)
		if (scl)
			starts++;
	always @(posedge sda)
		if (scl)
			stops++;

	// Hang guard
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_count++;
			final_report();
		end
	end

	task automatic final_report();
		if (err_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	task automatic chk(input string what, input logic [7:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk

	// One transfer: pulse go, wait for done under a bound
	task automatic op(input logic r, input logic [7:0] i, w);
		int n;
		n = 0;
		starts = 0;
		stops = 0;
		@(negedge mclk);
		go = 1'b1;
		cmd = '{rd: r, index: i, wdata: w};
		@(negedge mclk);
		go = 1'b0;
		while (done !== 1'b1 && n < 5000)
		begin
			@(negedge mclk);
			n++;
		end
		chk("done", {7'h0, done}, 8'h01);
	endtask : op

	task automatic rd_chk(input logic [7:0] i, exp);
		op(1'b1, i, 8'h00);
		chk("rdata", rdata, exp);
		chk("starts", 8'(starts), 8'h02);
		chk("stops", 8'(stops), 8'h01);
		chk("nack", {7'h0, nack}, 8'h00);
	endtask : rd_chk

	task automatic t_defaults();
		rd_chk(8'h01, SWITCH_TRIM_DEFAULT);
		rd_chk(8'h02, LINEAR_TRIM_DEFAULT);
		rd_chk(8'hFF, 8'h08);
	endtask : t_defaults

	task automatic t_write();
		op(1'b0, 8'h01, 8'h2A);
		chk("wstarts", 8'(starts), 8'h01);
		chk("wnack", {7'h0, nack}, 8'h00);
		rd_chk(8'h01, 8'h2A);
		op(1'b0, 8'h02, 8'hFC);
		rd_chk(8'h02, 8'h0C);
		op(1'b0, 8'hFF, 8'h05);
		rd_chk(8'hFF, 8'h18);
	endtask : t_write

	// A second go while busy is ignored
	task automatic t_refuse();
		op(1'b0, 8'h01, 8'h11);
		repeat (10) @(negedge mclk);
		fork
			op(1'b0, 8'h01, 8'h22);
			begin
				repeat (30) @(negedge mclk);
				go = 1'b1;
				cmd = '{rd: 1'b0, index: 8'h01, wdata: 8'h33};
				@(negedge mclk);
				go = 1'b0;
			end
		join
		repeat (20) @(negedge mclk);
		chk("busy", {7'h0, busy}, 8'h00);
		rd_chk(8'h01, 8'h22);
	endtask : t_refuse

	// Foreign address: slave stays released, nothing written
	task automatic t_nack();
		own_addr = 7'h29;
		op(1'b0, 8'h01, 8'h00);
		chk("nack", {7'h0, nack}, 8'h01);
		own_addr = 7'h28;
		rd_chk(8'h01, 8'h22);
	endtask : t_nack

	initial
	begin
		repeat (6) @(negedge mclk);
		rst = 1'b0;
		t_defaults();
		t_write();
		t_refuse();
		t_nack();
		final_report();
	end
endmodule : trim_link_master_tb_top
